// file: rtl/virt_cap_bank.sv
// Read-only capability register bank with field encoding decoder and
// guest-function entry check.
// Assumes one core clock; all inputs come from logic on that clock.
//
// Behaviour
// - Must-be-one mask shows bits pinned to one
// - May-be-one mask zero where bit pinned zero
// - Both masks stay mutually consistent
// - Field encoding layout: width, type, index, access
// - Enumeration reports highest index, rest zero
// - Bit 0 reports execute-only translations
// - Bit 6 reports four-level walk
// - Bits 8, 14 report uncached, write-back types
// - Bits 16, 17 report 2M, 1G mappings
// - Bits 20, 25, 26 report invalidate support
// - Bit 21 reports accessed and dirty flags
// - Bit 22 gates extended violation information
// - Bit 23 reports shadow-stack control
// - Bits 32, 40-43 report tag invalidate
// - Reserved capability bits read zero
// - Paging register exists only when supported
// - Entry fails on unallowed guest-function bit
// - Guest-function register exists only when supported
// - 16-bit fields permit only even encodings
// - Type 0 control, type 2 guest state
// - Control encodings present per enabling control
// - Guest-state selector and status encodings
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "virt_cap_consts.svh"

module virt_cap_bank
   import virt_cap_pkg::*;
#(
   parameter logic [63:0] CR4_MUST_BE_ONE = 64'h0000_0000_0000_2000,
   parameter logic [63:0] CR4_MAY_BE_ONE = 64'h0000_0000_0037_27ff,
   parameter logic [63:0] GUEST_FUNC_MASK = 64'h0000_0000_0000_0001,
   parameter bit HAS_SECONDARY = 1'b1,
   parameter bit HAS_SLT = 1'b1,
   parameter bit HAS_PROC_TAG = 1'b1,
   parameter bit HAS_GUEST_FUNC = 1'b1,
   parameter bit HAS_POSTED_INT = 1'b1,
   parameter bit HAS_VIOL_VE = 1'b1,
   parameter bit HAS_VINT_DELIVERY = 1'b1,
   parameter bit HAS_PML = 1'b1,
   parameter bit CAP_EXEC_ONLY = 1'b1,
   parameter bit CAP_WALK4 = 1'b1,
   parameter bit CAP_UC = 1'b1,
   parameter bit CAP_WB = 1'b1,
   parameter bit CAP_MAP_2M = 1'b1,
   parameter bit CAP_MAP_1G = 1'b1,
   parameter bit CAP_SLI = 1'b1,
   parameter bit CAP_SLI_SINGLE = 1'b1,
   parameter bit CAP_SLI_ALL = 1'b1,
   parameter bit CAP_AD = 1'b1,
   parameter bit CAP_ADV_EXIT = 1'b1,
   parameter bit CAP_SSS = 1'b0,
   parameter bit CAP_PTI = 1'b1,
   parameter logic [3:0] CAP_PTI_KINDS = 4'hf
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [`ADDR_W-1:0] addr_i,
   input wire logic [`DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`DATA_W-1:0] rdata_o,
   output logic rd_err_o,
   output logic wr_ignored_o,
   input wire logic [31:0] field_enc_i,
   output field_decode_t field_dec_o,
   input wire logic entry_req_i,
   input wire logic [63:0] guest_func_ctrl_i,
   input wire logic secondary_active_i,
   input wire logic guest_func_enable_i,
   output logic entry_done_o,
   output logic entry_fail_o,
   input wire logic [63:0] viol_info_i,
   output logic [63:0] viol_info_o
);

   // ----------------------------------------
   // Fixed register contents
   // ----------------------------------------
   localparam logic [63:0] CR4_ONE_MASK = CR4_MUST_BE_ONE;
   localparam logic [63:0] CR4_MAY_MASK = CR4_MAY_BE_ONE | CR4_MUST_BE_ONE;

   localparam bit PAGING_PRESENT = HAS_SECONDARY && (HAS_SLT || HAS_PROC_TAG);
   localparam bit FUNC_PRESENT = HAS_SECONDARY && HAS_GUEST_FUNC;

   localparam logic [8:0] MAX_INDEX = HAS_PML ? `IDX_GST_PML_INDEX :
      (HAS_VINT_DELIVERY ? `IDX_GST_INT_STATUS : `IDX_GST_SEL_MAX);

   function automatic logic [63:0] build_paging_cap();
      logic [63:0] v;
      v = 64'h0;
      v[`PCAP_EXEC_ONLY] = CAP_EXEC_ONLY;
      v[`PCAP_WALK4] = CAP_WALK4;
      v[`PCAP_UC] = CAP_UC;
      v[`PCAP_WB] = CAP_WB;
      v[`PCAP_MAP_2M] = CAP_MAP_2M;
      v[`PCAP_MAP_1G] = CAP_MAP_1G;
      v[`PCAP_SLI] = CAP_SLI;
      v[`PCAP_SLI_SINGLE] = CAP_SLI & CAP_SLI_SINGLE;
      v[`PCAP_SLI_ALL] = CAP_SLI & CAP_SLI_ALL;
      v[`PCAP_AD] = CAP_AD;
      v[`PCAP_ADV_EXIT] = CAP_ADV_EXIT;
      v[`PCAP_SSS] = CAP_SSS;
      v[`PCAP_PTI] = CAP_PTI;
      v[`PCAP_PTI_KIND_LO +: 4] = CAP_PTI ? CAP_PTI_KINDS : 4'h0;
      return v & ~(`PCAP_RESERVED_MASK);
   endfunction

   localparam logic [63:0] PAGING_CAP = build_paging_cap();
   localparam logic [63:0] FIELD_ENUM = {54'h0, MAX_INDEX, 1'b0};

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   function automatic logic [64:0] read_reg(input logic [`ADDR_W-1:0] a);
      logic [64:0] r;
      r = {1'b0, 64'h0};
      unique case (a)
         `OFS_CR4_MUST_BE_ONE: r = {1'b1, CR4_ONE_MASK};
         `OFS_CR4_MAY_BE_ONE: r = {1'b1, CR4_MAY_MASK};
         `OFS_FIELD_ENUM: r = {1'b1, FIELD_ENUM};
         `OFS_PAGING_CAP: r = PAGING_PRESENT ? {1'b1, PAGING_CAP} : {1'b0, 64'h0};
         `OFS_GUEST_FUNC: r = FUNC_PRESENT ? {1'b1, GUEST_FUNC_MASK} : {1'b0, 64'h0};
         default: r = {1'b0, 64'h0};
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // Field encoding decode
   // ----------------------------------------
   function automatic field_decode_t decode_field(input logic [31:0] e);
      field_decode_t d;
      logic zero_ok;
      logic [8:0] idx;
      d = '0;
      idx = e[`ENC_INDEX_HI:`ENC_INDEX_LO];
      zero_ok = ~|e[`ENC_RSVD_HI:`ENC_RSVD_LO] & ~e[`ENC_RSVD_MID];
      d.width = field_width_t'(e[`ENC_WIDTH_HI:`ENC_WIDTH_LO]);
      d.ftype = field_type_t'(e[`ENC_TYPE_HI:`ENC_TYPE_LO]);
      d.index = idx;
      d.high_access = e[`ENC_ACCESS];
      d.well_formed = zero_ok & ~((d.width == width_16_t_w) & e[`ENC_ACCESS]);
      if (d.well_formed && d.width == width_16_t_w) begin
         unique case (d.ftype)
            type_control: begin
               d.known = idx <= `IDX_CTL_MAX;
               unique case (e)
                  `ENC_CTL_PROC_TAG: d.present = HAS_PROC_TAG;
                  `ENC_CTL_PI_VECTOR: d.present = HAS_POSTED_INT;
                  `ENC_CTL_ROOT_LIST_IDX: d.present = HAS_VIOL_VE;
                  default: d.present = 1'b0;
               endcase
            end
            type_guest: begin
               d.known = idx <= `IDX_GST_PML_INDEX;
               if (e >= `ENC_GST_SEL_FIRST && e <= `ENC_GST_SEL_LAST) begin
                  d.present = 1'b1;
               end else if (e == `ENC_GST_INT_STATUS) begin
                  d.present = HAS_VINT_DELIVERY;
               end else if (e == `ENC_GST_PML_INDEX) begin
                  d.present = HAS_PML;
               end else begin
                  d.present = 1'b0;
               end
            end
            type_exit_info, type_host: begin
               d.known = 1'b0;
               d.present = 1'b0;
            end
         endcase
      end
      return d;
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   bank_state_t state_ff;
   bank_state_t nxt_state;
   logic [64:0] rd_word;
   logic [63:0] allowed_func;

   always_comb begin
      nxt_state = state_ff;
      rd_word = read_reg(addr_i);
      allowed_func = FUNC_PRESENT ? GUEST_FUNC_MASK : 64'h0;
      // Read data stand one cycle only
      nxt_state.rdata = rd_i ? rd_word[63:0] : 64'h0;
      nxt_state.rd_err = rd_i & ~rd_word[64];
      // Writes never change contents
      nxt_state.wr_ignored = wr_i;
      nxt_state.dec = decode_field(field_enc_i);
      nxt_state.entry_done = entry_req_i;
      nxt_state.entry_fail = entry_req_i & secondary_active_i & guest_func_enable_i
         & |(guest_func_ctrl_i & ~allowed_func);
      nxt_state.viol_info = (PAGING_PRESENT && PAGING_CAP[`PCAP_ADV_EXIT]) ? viol_info_i : 64'h0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rdata_o = state_ff.rdata;
   assign rd_err_o = state_ff.rd_err;
   assign wr_ignored_o = state_ff.wr_ignored;
   assign field_dec_o = state_ff.dec;
   assign entry_done_o = state_ff.entry_done;
   assign entry_fail_o = state_ff.entry_fail;
   assign viol_info_o = state_ff.viol_info;

endmodule // virt_cap_bank

// file: rtl/virt_cap_consts.svh
// Offsets, field positions and fixed masks of the capability register bank.
// Assumes inclusion by the package and the bank module only.
`ifndef VIRT_CAP_CONSTS_SVH
`define VIRT_CAP_CONSTS_SVH

// ----------------------------------------
// Register offsets (word addresses)
// ----------------------------------------
`define OFS_CR4_MUST_BE_ONE 12'h488
`define OFS_CR4_MAY_BE_ONE 12'h489
`define OFS_FIELD_ENUM 12'h48a
`define OFS_PAGING_CAP 12'h48c
`define OFS_GUEST_FUNC 12'h491
`define ADDR_W 12
`define DATA_W 64

// ----------------------------------------
// Paging and tag capability bit positions
// ----------------------------------------
`define PCAP_EXEC_ONLY 0
`define PCAP_WALK4 6
`define PCAP_UC 8
`define PCAP_WB 14
`define PCAP_MAP_2M 16
`define PCAP_MAP_1G 17
`define PCAP_SLI 20
`define PCAP_AD 21
`define PCAP_ADV_EXIT 22
`define PCAP_SSS 23
`define PCAP_SLI_SINGLE 25
`define PCAP_SLI_ALL 26
`define PCAP_PTI 32
`define PCAP_PTI_KIND_LO 40
`define PCAP_RESERVED_MASK 64'hffff_f0fe_f90c_bebe

// ----------------------------------------
// Field encoding layout
// ----------------------------------------
`define ENC_RSVD_HI 31
`define ENC_RSVD_LO 15
`define ENC_WIDTH_HI 14
`define ENC_WIDTH_LO 13
`define ENC_RSVD_MID 12
`define ENC_TYPE_HI 11
`define ENC_TYPE_LO 10
`define ENC_INDEX_HI 9
`define ENC_INDEX_LO 1
`define ENC_ACCESS 0

// ----------------------------------------
// Known 16-bit encodings
// ----------------------------------------
`define ENC_CTL_PROC_TAG 32'h0000_0000
`define ENC_CTL_PI_VECTOR 32'h0000_0002
`define ENC_CTL_ROOT_LIST_IDX 32'h0000_0004
`define ENC_GST_SEL_FIRST 32'h0000_0800
`define ENC_GST_SEL_LAST 32'h0000_080e
`define ENC_GST_INT_STATUS 32'h0000_0810
`define ENC_GST_PML_INDEX 32'h0000_0812
`define IDX_CTL_MAX 9'h002
`define IDX_GST_SEL_MAX 9'h007
`define IDX_GST_INT_STATUS 9'h008
`define IDX_GST_PML_INDEX 9'h009

`endif

// file: rtl/virt_cap_pkg.sv
// Types shared by the capability register bank.
// Assumes the constants header sits beside it.
package virt_cap_pkg;
`include "virt_cap_consts.svh"

   typedef enum logic [1:0] {
      width_16_t_w = 2'h0,
      width_64_t_w = 2'h1,
      width_32_t_w = 2'h2,
      width_nat_t_w = 2'h3
   } field_width_t;

   typedef enum logic [1:0] {
      type_control = 2'h0,
      type_exit_info = 2'h1,
      type_guest = 2'h2,
      type_host = 2'h3
   } field_type_t;

   typedef struct packed {
      logic well_formed;
      logic known;
      logic present;
      field_width_t width;
      field_type_t ftype;
      logic [8:0] index;
      logic high_access;
   } field_decode_t;

   typedef struct packed {
      logic [`DATA_W-1:0] rdata;
      logic rd_err;
      logic wr_ignored;
      field_decode_t dec;
      logic entry_done;
      logic entry_fail;
      logic [`DATA_W-1:0] viol_info;
   } bank_state_t;
endpackage

// file: tb/virt_cap_bank_properties.sv
// Port assertions for the capability bank.
// Assumes it is bound into virt_cap_bank.
`timescale 1ns/1ps

module virt_cap_bank_chk
   import virt_cap_pkg::*;
#(
   parameter logic [63:0] GUEST_FUNC_MASK = 64'h1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [11:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [63:0] rdata_o,
   input wire logic rd_err_o,
   input wire logic wr_ignored_o,
   input wire logic [31:0] field_enc_i,
   input wire field_decode_t field_dec_o,
   input wire logic entry_req_i,
   input wire logic [63:0] guest_func_ctrl_i,
   input wire logic secondary_active_i,
   input wire logic guest_func_enable_i,
   input wire logic entry_done_o,
   input wire logic entry_fail_o
);
   // ----
   // Checks
   // ----
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] enc_ff;
   always_ff @(posedge clk_i) enc_ff <= field_enc_i;
   property p_rsvd_zero;
      rd_i && addr_i == 12'h48c |=> (rdata_o & 64'hffff_f0fe_f90c_bebe) == 64'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");
   property p_enum;
      rd_i && addr_i == 12'h48a |=> rdata_o[63:10] == 54'h0 && !rdata_o[0] && rdata_o[9:1] != 9'h0;
   endproperty
   a_enum: assert property (p_enum) else $error("bad enumeration");
   property p_fixed_pair;
      rd_i && addr_i == 12'h488 ##1 rd_i && addr_i == 12'h489 |=> ($past(rdata_o) & ~rdata_o) == 64'h0;
   endproperty
   a_fixed_pair: assert property (p_fixed_pair) else $error("masks disagree");
   property p_wr_ro;
      wr_i |=> wr_ignored_o && rdata_o == 64'h0 && !rd_err_o;
   endproperty
   a_wr_ro: assert property (p_wr_ro) else $error("write not ignored");
   property p_unmapped;
      rd_i && !(addr_i inside {12'h488, 12'h489, 12'h48a, 12'h48c, 12'h491}) |=> rd_err_o && rdata_o == 64'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_entry_fail;
      entry_req_i && secondary_active_i && guest_func_enable_i && |(guest_func_ctrl_i & ~GUEST_FUNC_MASK)
         |=> entry_done_o && entry_fail_o;
   endproperty
   a_entry_fail: assert property (p_entry_fail) else $error("entry not failed");
   property p_odd_short;
      field_enc_i[14:13] == 2'h0 && field_enc_i[0] |=> !field_dec_o.well_formed;
   endproperty
   a_odd_short: assert property (p_odd_short) else $error("odd short encoding");
   property p_layout;
      field_enc_i[31:15] == 17'h0 && !field_enc_i[12] && !field_enc_i[0] |=> field_dec_o.well_formed
         && field_dec_o.index == enc_ff[9:1] && field_dec_o.ftype == enc_ff[11:10] && field_dec_o.width == enc_ff[14:13];
   endproperty
   a_layout: assert property (p_layout) else $error("bad decode");
   c_cap: cover property (rd_i && addr_i == 12'h48c);
   c_fail: cover property (entry_fail_o);
   c_wr: cover property (wr_ignored_o);
endmodule // virt_cap_bank_chk

bind virt_cap_bank virt_cap_bank_chk #(.GUEST_FUNC_MASK(GUEST_FUNC_MASK)) chk (.clk_i(clk_i), .rst_i(rst_i),
   .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rd_err_o(rd_err_o), .wr_ignored_o(wr_ignored_o),
   .field_enc_i(field_enc_i), .field_dec_o(field_dec_o), .entry_req_i(entry_req_i),
   .guest_func_ctrl_i(guest_func_ctrl_i), .secondary_active_i(secondary_active_i),
   .guest_func_enable_i(guest_func_enable_i), .entry_done_o(entry_done_o), .entry_fail_o(entry_fail_o));

// file: tb/virt_cap_bank_tb.sv
// Self-checking bench for the capability bank.
// Assumes the bank and its checker are compiled first.
`timescale 1ns/1ps

module virt_cap_bank_tb;
   import virt_cap_pkg::*;
   localparam logic [63:0] GFM = 64'h1;
   logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, entry_req_i = 0, secondary_active_i = 0;
   logic guest_func_enable_i = 0, rd_v = 0, wr_v = 0, en_v = 0, dv = 0, dec_go = 0;
   logic rd_err_o, wr_ignored_o, entry_done_o, entry_fail_o;
   logic [11:0] addr_i = 0;
   logic [63:0] wdata_i = 0, guest_func_ctrl_i = 0, viol_info_i = 0, rdata_o, viol_info_o;
   logic [31:0] field_enc_i = 0;
   field_decode_t field_dec_o;
   logic [64:0] exp_q[$];
   logic [64:0] got;
   logic rst_d = 1;
   logic [63:0] vi_d = 0;
   int error_cnt = 0, checks_done = 0, cyc = 0, sd;

   virt_cap_bank #(.GUEST_FUNC_MASK(GFM)) uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rd_err_o(rd_err_o), .wr_ignored_o(wr_ignored_o),
      .field_enc_i(field_enc_i), .field_dec_o(field_dec_o), .entry_req_i(entry_req_i),
      .guest_func_ctrl_i(guest_func_ctrl_i), .secondary_active_i(secondary_active_i),
      .guest_func_enable_i(guest_func_enable_i), .entry_done_o(entry_done_o), .entry_fail_o(entry_fail_o),
      .viol_info_i(viol_info_i), .viol_info_o(viol_info_o));

   // ----
   // Clock, monitor, tasks
   // ----
   initial forever #12.5 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      rd_v <= rd_i;
      wr_v <= wr_i;
      en_v <= entry_req_i;
      dv <= dec_go;
      viol_info_i <= {$urandom, $urandom};
      rst_d <= rst_i;
      vi_d <= viol_info_i;
      cyc <= cyc + 1;
      if (cyc > 3000) begin
         error_cnt++;
         results();
      end
   end

   always @(negedge clk_i) if (rd_v | wr_v | en_v | dv) begin
      got = wr_v ? {rdata_o, wr_ignored_o} : rd_v ? {rd_err_o, rdata_o} :
         en_v ? 65'({entry_done_o, entry_fail_o}) : 65'(field_dec_o);
      checks_done++;
      if (got !== exp_q[0]) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp_q[0]);
      end
      exp_q.pop_front();
   end

   always @(negedge clk_i) if (!rst_d) begin
      checks_done++;
      if (viol_info_o !== vi_d) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, viol_info_o, vi_d);
      end
   end

   task automatic bus(input logic r, input logic [11:0] a, input logic [64:0] e);
      rd_i <= r;
      wr_i <= !r;
      addr_i <= a;
      wdata_i <= {$urandom, $urandom};
      exp_q.push_back(e);
      @(posedge clk_i);
   endtask

   task automatic dec(input logic [31:0] f, input logic [16:0] e);
      dec_go <= 1'b1;
      field_enc_i <= f;
      exp_q.push_back(65'(e));
      @(posedge clk_i);
   endtask

   task automatic ent(input logic s, input logic g, input logic [63:0] c);
      entry_req_i <= 1'b1;
      secondary_active_i <= s;
      guest_func_enable_i <= g;
      guest_func_ctrl_i <= c;
      exp_q.push_back({63'h0, 1'b1, s & g & |(c & ~GFM)});
      @(posedge clk_i);
   endtask

   task automatic idle();
      {rd_i, wr_i, dec_go, entry_req_i} <= 4'h0;
      repeat (2) @(posedge clk_i);
   endtask

   task automatic results();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      sd = $urandom(32'h6f5aa7fa);
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1, 12'h488, 65'h2000);
      bus(1, 12'h489, 65'h3727ff);
      bus(1, 12'h48a, 65'h12);
      bus(1, 12'h48c, 65'h0f01_0673_4141);
      bus(1, 12'h491, 65'h1);
      bus(1, 12'h48b, {1'b1, 64'h0});
      bus(0, 12'h48c, 65'h1);
      bus(1, 12'h48c, 65'h0f01_0673_4141);
      bus(0, 12'h491, 65'h1);
      bus(1, 12'h491, 65'h1);
      idle();
      $display("register test done");
      for (int i = 0; i < 3; i++) dec(32'(2 * i), {3'h7, 4'h0, 9'(i), 1'b0});
      for (int i = 0; i < 10; i++) dec(32'(2048 + 2 * i), {3'h7, 4'h2, 9'(i), 1'b0});
      dec(32'h814, {3'h4, 4'h2, 9'h00a, 1'b0});
      dec(32'h803, {3'h0, 4'h2, 9'h001, 1'b1});
      idle();
      $display("decode test done");
      for (int k = 0; k < 8; k++) ent(k[0], k[1], k[2] ? {$urandom, $urandom} | 64'h2 : GFM);
      idle();
      $display("entry test done");
      results();
   end
endmodule // virt_cap_bank_tb
